// ---- bench/board_model.sv ----
// Board side of the forty port pins: pull-ups and an external low driver.
`timescale 1ns/1ps
module board_model (
  // Drive from the block
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe_b,
  // Board stimulus, high pulls the pin low while it is released
  input wire logic [39:0] ext_low,
  // Pad levels back to the block
  output logic [39:0] pin_in
);
  // The block's strong drive wins; a released pin goes to the pull-up unless held low.
  assign pin_in = (~pin_oe_b & pin_out) | (pin_oe_b & ~ext_low);
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the forty-pin general purpose port block.
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module tb_top;
  logic clk = 0, rst_b = 0, chk = 0;
  logic [4:0] mode_wr = '0, latch_wr = '0, w;
  logic [15:0] mode_wdata = '0, mdw;
  logic [7:0] latch_wdata = '0, ld;
  logic [79:0] pms, md;
  logic [39:0] pol, pls, pin_in, pout, poe_b, lt, ok, ext = '0;
  logic [239:0] exq[$];
  logic [31:0] rnd = 32'h2957_6c76;
  int miscompares = 0, checked = 0, n;
  always #2.5 clk = ~clk;
  gpio_port_modes u_gpio_port_modes (.CLK(clk), .RST_B(rst_b), .MODE_WR(mode_wr),
    .MODE_WDATA(mode_wdata), .LATCH_WR(latch_wr), .LATCH_WDATA(latch_wdata),
    .PORT_MODE_SELECT(pms), .PORT_OUTPUT_LATCH(pol), .PIN_LEVEL_SAMPLE(pls),
    .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE_B(poe_b));
  board_model u_board_model (.pin_out(pout), .pin_oe_b(poe_b), .ext_low(ext),
    .pin_in(pin_in));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Settled view; PIN_OUT is only meaningful where the pin is driven.
  function automatic logic [239:0] expv();
    logic [39:0] oe, dv;
    for (int i = 0; i < 40; i++) begin
      oe[i] = md[2*i+:2] == 2'h1 ? 1'b0 : md[2*i+:2] == 2'h0 ? 1'b1 : lt[i];
      dv[i] = oe[i] ? ~ext[i] : lt[i];
    end
    return {md, lt, oe, dv | oe, dv};
  endfunction
  task automatic note();
    exq.push_back(expv());
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask
  task automatic cmp(logic [239:0] got, logic [239:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (chk) cmp({pms, pol, poe_b, pout | poe_b, pls}, exq.pop_front());
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    md = '1;
    lt = '1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    note();
    for (int k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      w = rnd[4:0] | 5'(1 << (k % 5));
      ld = rnd[12:5];
      rnd = lfsr(rnd);
      mdw = rnd[15:0];
      for (int p = 0; p < 5; p++) if (w[p]) begin
        md[16*p+:16] = mdw;
        lt[8*p+:8] = ld;
      end
      for (int i = 0; i < 40; i++) ok[i] = md[2*i+:2] == 2'h0 || (md[2*i+:2] == 2'h2 && lt[i]);
      mode_wr <= w;
      mode_wdata <= mdw;
      latch_wr <= w;
      latch_wdata <= ld;
      ext <= {rnd, rnd[7:0]} & ok;
      @(posedge clk);
      mode_wr <= '0;
      latch_wr <= '0;
      repeat (12) @(posedge clk);
      note();
    end
    // Port 0 to quasi mode with latches set before its pins are sensed.
    mode_wr <= 5'h01;
    mode_wdata <= 16'hffff;
    latch_wr <= 5'h01;
    latch_wdata <= 8'hff;
    ext <= '0;
    @(posedge clk);
    mode_wr <= '0;
    latch_wr <= '0;
    repeat (12) @(posedge clk);
    ext <= 40'h1;
    @(posedge clk);
    ext <= '0;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      n += (poe_b[0] === 1'b0 && pout[0] === 1'b1);
    end
    cmp(240'(n), 240'd2);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    md = '1;
    lt = '1;
    @(posedge clk);
    note();
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule

// ---- hdl/gpio_pin_ctrl.sv ----
// One pin's mode decoding, synchroniser and quasi-bidirectional pulse.
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module gpio_pin_ctrl
  import gpio_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic [1:0] mode,
  input wire logic latch,
  // Pin
  input wire logic pin_in,
  output logic level,
  output pin_drive_t drive
);

  logic sync1_q;
  logic sync2_q;
  logic [`BOOST_CNT_W-1:0] boost_q;
  logic [`BOOST_CNT_W-1:0] boost_d;
  logic boost_on;
  logic start_boost;
  logic drv_low;
  logic drv_high;

  // ---------------------------------------------------------------
  // Synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end
  assign level = sync2_q;

  // ---------------------------------------------------------------
  // Quasi-bidirectional boost
  // ---------------------------------------------------------------
  // A new pulse is only started when idle, but with the pad drive registered in the top the synchroniser
  // then still shows the level from before the pulse reached the pin, so a pin low at that point retriggers.
  assign boost_on = (boost_q != '0);
  assign start_boost = (mode == MODE_QUASI) && latch && !sync2_q && !boost_on;
  always_comb begin
    boost_d = boost_q;
    if (mode != MODE_QUASI || !latch) begin
      boost_d = '0;
    end else if (start_boost) begin
      boost_d = `BOOST_CNT_W'(`BOOST_CYCLES);
    end else if (boost_on) begin
      boost_d = boost_q - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_q <= '0;
    end else begin
      boost_q <= boost_d;
    end
  end

  // ---------------------------------------------------------------
  // Driver decode
  // ---------------------------------------------------------------
  assign drv_low = !latch && (mode != MODE_INPUT);
  assign drv_high = latch && ((mode == MODE_PUSH_PULL) || boost_on);
  // One assignment for the whole carrier, so it has a single driver.
  assign drive = '{drive_val: latch, drive_oe_b: !(drv_low || drv_high)};

  a_boost_len: assert property (@(posedge clk) disable iff (!rst_b)
    start_boost |=> boost_on [*2] ##1 !boost_on)
    else $error("Quasi strong high pulse is not two cycles.");
  a_input_float: assert property (@(posedge clk) disable iff (!rst_b)
    (mode == MODE_INPUT) |-> drive.drive_oe_b)
    else $error("Input mode pin is driven.");
  a_open_drain: assert property (@(posedge clk) disable iff (!rst_b)
    (mode == MODE_OPEN_DRAIN) |-> (drive.drive_oe_b == latch))
    else $error("Open-drain drive does not follow the latch.");
endmodule

// ---- hdl/gpio_port_defs.svh ----
// Constants for the general purpose pin ports; the types are in gpio_port_pkg.
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define PORT_COUNT 5
`define PORT_PINS 8
`define PIN_COUNT 40
`define LATCH_RESET 8'hFF
`define MODE_RESET 2'h3
// Strong high pulse length in clock cycles.
`define BOOST_CYCLES 2
`define BOOST_CNT_W 2

`endif

// ---- hdl/gpio_port_modes.sv ----
// Top of the forty-pin general purpose port block.
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module gpio_port_modes
  import gpio_port_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Configuration writes, one strobe per port
  input wire logic [`PORT_COUNT-1:0] MODE_WR,
  input wire logic [2*`PORT_PINS-1:0] MODE_WDATA,
  input wire logic [`PORT_COUNT-1:0] LATCH_WR,
  input wire logic [`PORT_PINS-1:0] LATCH_WDATA,
  // Register views
  output logic [2*`PIN_COUNT-1:0] PORT_MODE_SELECT,
  output logic [`PIN_COUNT-1:0] PORT_OUTPUT_LATCH,
  output logic [`PIN_COUNT-1:0] PIN_LEVEL_SAMPLE,
  // Pins
  input wire logic [`PIN_COUNT-1:0] PIN_IN,
  output logic [`PIN_COUNT-1:0] PIN_OUT,
  output logic [`PIN_COUNT-1:0] PIN_OE_B
);

  logic [2*`PIN_COUNT-1:0] mode_q;
  logic [`PIN_COUNT-1:0] latch_q;
  logic [`PIN_COUNT-1:0] level_w;
  pin_drive_t drive_w [`PIN_COUNT];

  // ---------------------------------------------------------------
  // Mode and latch registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_q <= {`PIN_COUNT{`MODE_RESET}};
      latch_q <= {`PORT_COUNT{`LATCH_RESET}};
    end else begin
      for (int p = 0; p < `PORT_COUNT; p++) begin
        if (MODE_WR[p]) begin
          mode_q[p*2*`PORT_PINS +: 2*`PORT_PINS] <= MODE_WDATA;
        end
        if (LATCH_WR[p]) begin
          latch_q[p*`PORT_PINS +: `PORT_PINS] <= LATCH_WDATA;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-pin control
  // ---------------------------------------------------------------
  for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
    gpio_pin_ctrl u_pin (
      .clk(CLK),
      .rst_b(RST_B),
      .mode(mode_q[2*i +: 2]),
      .latch(latch_q[i]),
      .pin_in(PIN_IN[i]),
      .level(level_w[i]),
      .drive(drive_w[i])
    );
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // Registering the drive adds one cycle of pin latency; the two-cycle
  // boost keeps its length since both edges shift together.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_MODE_SELECT <= {`PIN_COUNT{`MODE_RESET}};
      PORT_OUTPUT_LATCH <= {`PORT_COUNT{`LATCH_RESET}};
      PIN_LEVEL_SAMPLE <= '1;
      PIN_OUT <= '1;
      PIN_OE_B <= '1;
    end else begin
      PORT_MODE_SELECT <= mode_q;
      PORT_OUTPUT_LATCH <= latch_q;
      PIN_LEVEL_SAMPLE <= level_w;
      for (int k = 0; k < `PIN_COUNT; k++) begin
        PIN_OUT[k] <= drive_w[k].drive_val;
        PIN_OE_B[k] <= drive_w[k].drive_oe_b;
      end
    end
  end

  a_reset_quasi: assert property (@(posedge CLK)
    $rose(RST_B) |-> (mode_q == {`PIN_COUNT{`MODE_RESET}}) && (&latch_q))
    else $error("Reset state is not quasi mode with latches set.");
  a_push_pull: assert property (@(posedge CLK) disable iff (!RST_B)
    (mode_q[1:0] == MODE_PUSH_PULL) && !MODE_WR[0] && !LATCH_WR[0]
      |=> !PIN_OE_B[0] && (PIN_OUT[0] == latch_q[0]))
    else $error("Push-pull pin does not follow its latch.");
  a_quasi_low: assert property (@(posedge CLK) disable iff (!RST_B)
    (mode_q[1:0] == MODE_QUASI) && !latch_q[0] && !MODE_WR[0] && !LATCH_WR[0]
      |=> !PIN_OE_B[0] && !PIN_OUT[0])
    else $error("Quasi pin with latch zero is not driven low.");
  a_mode_write: assert property (@(posedge CLK) disable iff (!RST_B)
    MODE_WR[1] |=> ##1 PORT_MODE_SELECT[16 +: 16] == $past(MODE_WDATA, 2))
    else $error("Mode write did not reach the view.");
  a_level_path: assert property (@(posedge CLK) disable iff (!RST_B)
    ##3 PIN_LEVEL_SAMPLE[0] == $past(PIN_IN[0], 3))
    else $error("Pin level sample is not three cycles behind the pin.");
  a_latch_write: assert property (@(posedge CLK) disable iff (!RST_B)
    LATCH_WR[4] |=> ##1 PORT_OUTPUT_LATCH[32 +: 8] == $past(LATCH_WDATA, 2))
    else $error("Latch write did not reach the view.");
  a_input_top: assert property (@(posedge CLK) disable iff (!RST_B)
    (mode_q[79:78] == MODE_INPUT) |=> PIN_OE_B[39])
    else $error("Input mode pin is driven at the pad.");
  a_drain_top: assert property (@(posedge CLK) disable iff (!RST_B)
    (mode_q[79:78] == MODE_OPEN_DRAIN) && !LATCH_WR[4]
      |=> (PIN_OE_B[39] == latch_q[39]) && (PIN_OE_B[39] || !PIN_OUT[39]))
    else $error("Open-drain pad does not follow its latch.");
endmodule

// ---- hdl/gpio_port_pkg.sv ----
// Types shared by the port logic.
package gpio_port_pkg;
  typedef enum logic [1:0] {
    MODE_INPUT = 2'h0,
    MODE_PUSH_PULL = 2'h1,
    MODE_OPEN_DRAIN = 2'h2,
    MODE_QUASI = 2'h3
  } pin_mode_field_t;

  typedef struct packed {
    logic drive_val;
    logic drive_oe_b;
  } pin_drive_t;
endpackage
